// [logic/port_polarity_defs.vh]
// register offsets, field positions and reset values of the polarity bank
`ifndef PORT_POLARITY_DEFS_VH
`define PORT_POLARITY_DEFS_VH
`define LINE_POL_OFFSET     8'h04
`define FRAMER_POL_OFFSET   8'h06
`define STATUS_OFFSET       8'h08
`define MASK_OFFSET         8'h0C
`define POL_RESET           16'h0000
`define LINE_POL_WMASK      16'h0F3F
`define FRAMER_POL_WMASK    16'h00FF
`define STAT_WMASK          16'h0007
`define HS_TX_CLK_BIT       0
`define HS_TX_DAT_BIT       1
`define HS_RX_CLK_BIT       2
`define HS_RX_DAT_BIT       3
`define HS_FORCE_HI_BIT     4
`define HS_FORCE_LO_BIT     5
`define LS_TX_CLK_BIT       8
`define LS_TX_DAT_BIT       9
`define LS_RX_CLK_BIT       10
`define LS_RX_DAT_BIT       11
`define FR_TX_EN_BIT        0
`define FR_TX_DAT_BIT       1
`define FR_TX_CLK_BIT       2
`define FR_TX_SYNC_BIT      3
`define FR_RX_EN_BIT        4
`define FR_RX_DAT_BIT       5
`define FR_RX_CLK_BIT       6
`define FR_RX_SYNC_BIT      7
`define ST_TICK_BIT         0
`define ST_FRAME_LOSS_BIT   1
`define ST_CLOCK_LOSS_BIT   2
`define TRIB_CHANNELS       28
`endif

// [logic/port_polarity_and_status_bits.v]
// port polarity registers and status bits with a wishbone slave
// Notes on behaviour
// - bit 0 of line register inverts the line transmit clock.
// - bit 1 inverts both line transmit data outputs.
// - bit 2 inverts the line receive clock before use.
// - bit 3 inverts both line receive data inputs.
// - while bit 4 is zero both line data outputs are forced high.
// - bit 5 one forces both line data outputs low while bit 4 is one.
// - bit 8 inverts all tributary transmit clock inputs, drops and common.
// - bit 9 inverts all tributary transmit data inputs.
// - bit 10 inverts all tributary receive clocks, drops and common.
// - bit 11 inverts all tributary receive data outputs.
// - framer register bits 0-3 invert tx enable, data, clock, frame sync.
// - framer register bits 4-7 invert rx enable, data, clock, frame sync.
// - event bit latches a pulse, interrupts, clears on a read unless a new pulse arrives in the same cycle.
// - alarm bit clears on read only once the alarm is gone.
// - alarm bit interrupts on both assertion and deassertion.
// - real-time bit follows its condition, interrupting while it lasts.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "port_polarity_defs.vh"
module port_polarity_and_status_bits (
   // clock and reset
   input  wire        clk,
   input  wire        reset,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   output reg         irq,
   // line side, core view and pins
   input  wire        core_line_tx_clock,
   input  wire        core_line_tx_positive,
   input  wire        core_line_tx_negative,
   output reg         line_tx_clock,
   output reg         line_tx_positive,
   output reg         line_tx_negative,
   input  wire        line_rx_clock,
   input  wire        line_rx_positive,
   input  wire        line_rx_negative,
   output reg         core_line_rx_clock,
   output reg         core_line_rx_positive,
   output reg         core_line_rx_negative,
   // tributary transmit pins to core
   input  wire [27:0] trib_tx_clock,
   input  wire        drop_a_tx_clock,
   input  wire        drop_b_tx_clock,
   input  wire        trib_tx_common_clock,
   input  wire [27:0] trib_tx_data,
   input  wire        drop_a_tx_data,
   input  wire        drop_b_tx_data,
   output reg  [30:0] core_trib_tx_clock,
   output reg  [29:0] core_trib_tx_data,
   // tributary receive core to pins
   input  wire [30:0] core_trib_rx_clock,
   input  wire [29:0] core_trib_rx_data,
   output reg  [27:0] trib_rx_clock,
   output reg         drop_a_rx_clock,
   output reg         drop_b_rx_clock,
   output reg         trib_rx_common_clock,
   output reg  [27:0] trib_rx_data,
   output reg         drop_a_rx_data,
   output reg         drop_b_rx_data,
   // framer transmit: core to pins
   input  wire [3:0]  core_framer_tx,
   output reg         framer_tx_data_enable,
   output reg         framer_tx_data,
   output reg         framer_tx_clock,
   output reg         framer_tx_frame_sync,
   // framer receive: pins to core
   input  wire        framer_rx_data_enable,
   input  wire        framer_rx_data,
   input  wire        framer_rx_clock,
   input  wire        framer_rx_frame_sync,
   output reg  [3:0]  core_framer_rx,
   // status conditions
   input  wire        one_second_tick_event,
   input  wire        frame_loss_alarm,
   input  wire        tx_clock_loss
);
   reg  [15:0] line_pol;
   reg  [15:0] framer_pol;
   reg  [2:0]  status;
   reg  [2:0]  mask;
   reg         alarm_prev;
   reg  [31:0] next_rdata;
   wire        req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        wr  = req & wb_we_i;
   wire        rd_status = req & ~wb_we_i & (wb_adr_i == `STATUS_OFFSET);
   wire        alarm_edge = frame_loss_alarm ^ alarm_prev;
   wire [15:0] wdata;
   wire        hs_data_out_en;
   // tributary transmit pins inverted before the single output register
   wire [30:0] next_tx_clock;
   wire [29:0] next_tx_data;

   // byte lanes 0 and 1 carry the 16-bit registers
   assign wdata = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
                   wb_sel_i[0] ? wb_dat_i[7:0]  : 8'h00};
   assign hs_data_out_en = line_pol[`HS_FORCE_HI_BIT];
   assign next_tx_clock[30:28] = {trib_tx_common_clock,
      drop_b_tx_clock, drop_a_tx_clock}
      ^ {3{line_pol[`LS_TX_CLK_BIT]}};
   assign next_tx_data[29:28] = {drop_b_tx_data, drop_a_tx_data}
      ^ {2{line_pol[`LS_TX_DAT_BIT]}};

   always @* begin
      next_rdata = 32'h00000000;
      case (wb_adr_i)
         `LINE_POL_OFFSET:   next_rdata[15:0] = line_pol;
         `FRAMER_POL_OFFSET: next_rdata[15:0] = framer_pol;
         `STATUS_OFFSET:     next_rdata[2:0]  = status;
         `MASK_OFFSET:       next_rdata[2:0]  = mask;
         default:            next_rdata = 32'h00000000;
      endcase
   end

   // single-cycle ack; unmapped addresses ack with zero data
   always @(posedge clk) begin
      if (reset) begin
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= 32'h00000000;
         line_pol   <= `POL_RESET;
         framer_pol <= `POL_RESET;
         mask       <= 3'h0;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? next_rdata : 32'h00000000;
         if (wr) begin
            // unselected lanes keep their bits
            if (wb_adr_i == `LINE_POL_OFFSET)
               line_pol <= ((wdata & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}})
                  | (line_pol & ~{{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}))
                  & `LINE_POL_WMASK;
            if (wb_adr_i == `FRAMER_POL_OFFSET)
               framer_pol <= ((wdata & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}})
                  | (framer_pol & ~{{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}))
                  & `FRAMER_POL_WMASK;
            if (wb_adr_i == `MASK_OFFSET && wb_sel_i[0])
               mask <= wb_dat_i[2:0];
         end
      end
   end

   // status: a set arriving with the clearing read wins
   always @(posedge clk) begin
      if (reset) begin
         status     <= 3'h0;
         alarm_prev <= 1'b0;
         irq        <= 1'b0;
      end else begin
         alarm_prev <= frame_loss_alarm;
         if (one_second_tick_event)
            status[`ST_TICK_BIT] <= 1'b1;
         else if (rd_status)
            status[`ST_TICK_BIT] <= 1'b0;
         if (alarm_edge)
            status[`ST_FRAME_LOSS_BIT] <= 1'b1;
         else if (rd_status && !frame_loss_alarm)
            status[`ST_FRAME_LOSS_BIT] <= 1'b0;
         status[`ST_CLOCK_LOSS_BIT] <= tx_clock_loss;
         // one cycle late so the level matches the status register
         irq <= |(status & mask);
      end
   end

   // pin boundary: registered so every output is a flip-flop; the
   // one-cycle skew is the price of that and matches on all signals
   genvar i;
   generate
      for (i = 0; i < `TRIB_CHANNELS; i = i + 1) begin : trib
         assign next_tx_clock[i] = trib_tx_clock[i]
            ^ line_pol[`LS_TX_CLK_BIT];
         assign next_tx_data[i]  = trib_tx_data[i]
            ^ line_pol[`LS_TX_DAT_BIT];
         always @(posedge clk) begin
            if (reset) begin
               trib_rx_clock[i]      <= 1'b0;
               trib_rx_data[i]       <= 1'b0;
            end else begin
               trib_rx_clock[i]      <= core_trib_rx_clock[i]
                  ^ line_pol[`LS_RX_CLK_BIT];
               trib_rx_data[i]       <= core_trib_rx_data[i]
                  ^ line_pol[`LS_RX_DAT_BIT];
            end
         end
      end
   endgenerate

   always @(posedge clk) begin
      if (reset) begin
         core_trib_tx_clock        <= 31'h00000000;
         core_trib_tx_data         <= 30'h00000000;
         drop_a_rx_clock           <= 1'b0;
         drop_b_rx_clock           <= 1'b0;
         trib_rx_common_clock      <= 1'b0;
         drop_a_rx_data            <= 1'b0;
         drop_b_rx_data            <= 1'b0;
         line_tx_clock             <= 1'b0;
         line_tx_positive          <= 1'b1;
         line_tx_negative          <= 1'b1;
         core_line_rx_clock        <= 1'b0;
         core_line_rx_positive     <= 1'b0;
         core_line_rx_negative     <= 1'b0;
         framer_tx_data_enable     <= 1'b0;
         framer_tx_data            <= 1'b0;
         framer_tx_clock           <= 1'b0;
         framer_tx_frame_sync      <= 1'b0;
         core_framer_rx            <= 4'h0;
      end else begin
         core_trib_tx_clock <= next_tx_clock;
         core_trib_tx_data <= next_tx_data;
         drop_a_rx_clock <= core_trib_rx_clock[28]
            ^ line_pol[`LS_RX_CLK_BIT];
         drop_b_rx_clock <= core_trib_rx_clock[29]
            ^ line_pol[`LS_RX_CLK_BIT];
         trib_rx_common_clock <= core_trib_rx_clock[30]
            ^ line_pol[`LS_RX_CLK_BIT];
         drop_a_rx_data <= core_trib_rx_data[28]
            ^ line_pol[`LS_RX_DAT_BIT];
         drop_b_rx_data <= core_trib_rx_data[29]
            ^ line_pol[`LS_RX_DAT_BIT];
         line_tx_clock <= core_line_tx_clock
            ^ line_pol[`HS_TX_CLK_BIT];
         // force high outranks force low and inversion
         if (!hs_data_out_en) begin
            line_tx_positive <= 1'b1;
            line_tx_negative <= 1'b1;
         end else if (line_pol[`HS_FORCE_LO_BIT]) begin
            line_tx_positive <= 1'b0;
            line_tx_negative <= 1'b0;
         end else begin
            line_tx_positive <= core_line_tx_positive
               ^ line_pol[`HS_TX_DAT_BIT];
            line_tx_negative <= core_line_tx_negative
               ^ line_pol[`HS_TX_DAT_BIT];
         end
         core_line_rx_clock <= line_rx_clock
            ^ line_pol[`HS_RX_CLK_BIT];
         core_line_rx_positive <= line_rx_positive
            ^ line_pol[`HS_RX_DAT_BIT];
         core_line_rx_negative <= line_rx_negative
            ^ line_pol[`HS_RX_DAT_BIT];
         framer_tx_data_enable <= core_framer_tx[0]
            ^ framer_pol[`FR_TX_EN_BIT];
         framer_tx_data <= core_framer_tx[1]
            ^ framer_pol[`FR_TX_DAT_BIT];
         framer_tx_clock <= core_framer_tx[2]
            ^ framer_pol[`FR_TX_CLK_BIT];
         framer_tx_frame_sync <= core_framer_tx[3]
            ^ framer_pol[`FR_TX_SYNC_BIT];
         core_framer_rx <= {framer_rx_frame_sync, framer_rx_clock,
            framer_rx_data, framer_rx_data_enable}
            ^ framer_pol[7:4];
      end
   end
endmodule

// [verif/port_polarity_chk.sv]
// concurrent checks on the polarity and status block ports
`timescale 1ns/1ps
module port_polarity_chk (
   // clock, reset and bus
   input wire        clk,
   input wire        reset,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [7:0]  wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire        wb_ack_o,
   input wire        irq,
   // line transmit path and status inputs
   input wire        core_line_tx_clock,
   input wire        core_line_tx_positive,
   input wire        line_tx_clock,
   input wire        line_tx_positive,
   input wire        one_second_tick_event,
   input wire        tx_clock_loss
);
   // shadows load at the ack edge, a cycle after the bank does,
   // which lines up with the one-cycle registered pin paths
   reg [15:0] lp;
   reg [2:0]  mk;
   wire       wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
   always @(posedge clk) begin
      if (reset) begin
         lp <= 16'h0000;
         mk <= 3'h0;
      end else if (wr && wb_adr_i == 8'h04) begin
         lp <= wb_dat_i[15:0];
      end else if (wr && wb_adr_i == 8'h0C) begin
         mk <= wb_dat_i[2:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_idle: assert property (!wb_cyc_i |=> !wb_ack_o)
      else $error("ack without request");
   a_tx_clk_inv: assert property (!$past(reset) |->
      line_tx_clock == ($past(core_line_tx_clock) ^ lp[0]))
      else $error("line tx clock polarity wrong");
   a_tx_data_force: assert property (!$past(reset) |->
      line_tx_positive == (!lp[4] ? 1'h1 : lp[5] ? 1'h0 :
      ($past(core_line_tx_positive) ^ lp[1])))
      else $error("line tx data level wrong");
   a_tick_irq: assert property (one_second_tick_event && mk[0] |->
      ##[1:3] irq) else $error("tick event gave no interrupt");
   a_rt_irq: assert property ((tx_clock_loss && mk[2]) [*3] |-> irq)
      else $error("real-time condition gave no interrupt");
   a_irq_masked: assert property ((mk == 3'h0) [*2] |-> !irq)
      else $error("interrupt with all sources masked");
endmodule
bind port_polarity_and_status_bits port_polarity_chk i_port_polarity_chk (.*);

// [verif/port_polarity_and_status_bits_tb.sv]
// self-checking bench for the polarity and status block
`timescale 1ns/1ps
module port_polarity_and_status_bits_tb;
   reg        clk = 1'h0, reset = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
   reg        wb_we_i = 1'h0, core_line_tx_clock = 1'h1;
   reg [7:0]  wb_adr_i = 8'h00;
   reg [3:0]  wb_sel_i = 4'h3, core_framer_tx = 4'hA;
   reg [31:0] wb_dat_i = 32'h0, m;
   reg        core_line_tx_positive = 1'h0, core_line_tx_negative = 1'h1;
   reg        line_rx_clock = 1'h1, line_rx_positive = 1'h0;
   reg        line_rx_negative = 1'h1, drop_a_tx_clock = 1'h1;
   reg [27:0] trib_tx_clock = 28'hA5A5A5A, trib_tx_data = 28'h1234567;
   reg        drop_b_tx_clock = 1'h0, trib_tx_common_clock = 1'h1;
   reg        drop_a_tx_data = 1'h0, drop_b_tx_data = 1'h1;
   reg        framer_rx_data_enable = 1'h0, framer_rx_data = 1'h1;
   reg        framer_rx_clock = 1'h1, framer_rx_frame_sync = 1'h0;
   reg        one_second_tick_event = 1'h0, frame_loss_alarm = 1'h0;
   reg        tx_clock_loss = 1'h0;
   reg [30:0] core_trib_rx_clock = 31'h2A5A5A5A;
   reg [29:0] core_trib_rx_data = 30'h1234ABCD;
   reg [15:0] q;
   wire [31:0] wb_dat_o;
   wire [30:0] core_trib_tx_clock;
   wire [29:0] core_trib_tx_data;
   wire [27:0] trib_rx_clock, trib_rx_data;
   wire [3:0]  core_framer_rx;
   wire        wb_ack_o, irq, line_tx_clock, line_tx_positive, line_tx_negative;
   wire        core_line_rx_clock, core_line_rx_positive, core_line_rx_negative;
   wire        drop_a_rx_clock, drop_b_rx_clock, trib_rx_common_clock;
   wire        drop_a_rx_data, drop_b_rx_data, framer_tx_data_enable;
   wire        framer_tx_data, framer_tx_clock, framer_tx_frame_sync;
   wire [5:0]  lv = {line_tx_clock, line_tx_positive, line_tx_negative,
      core_line_rx_clock, core_line_rx_positive, core_line_rx_negative};
   integer     num_errors = 0, n_tests = 0, cycles = 0;
   port_polarity_and_status_bits i_port_polarity_and_status_bits (.*);
   initial forever #10 clk = ~clk;
   task final_report;
      begin
         if (num_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // whole run is about 150 cycles; the 3000-cycle ceiling leaves wide margin
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         num_errors = num_errors + 1;
         final_report;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // request held until the ack edge, then released for a cycle
   task bus(input w, input [7:0] a, input [15:0] d);
      begin
         @(posedge clk);
         wb_cyc_i <= 1'h1;
         wb_stb_i <= 1'h1;
         wb_we_i <= w;
         wb_adr_i <= a;
         wb_dat_i <= {16'h0000, d};
         @(posedge clk);
         while (wb_ack_o !== 1'h1) @(posedge clk);
         q = wb_dat_o[15:0];
         wb_cyc_i <= 1'h0;
         wb_stb_i <= 1'h0;
      end
   endtask
   task rdc(input [7:0] a, input [15:0] e);
      begin
         bus(1'h0, a, 16'h0000);
         chk(q, e);
      end
   endtask
   task wl(input [7:0] a, input [15:0] d);
      begin
         bus(1'h1, a, d);
         repeat (2) @(posedge clk);
      end
   endtask
   task t_regs;
      begin
         rdc(8'h04, 16'h0000);
         rdc(8'h06, 16'h0000);
         chk({line_tx_positive, line_tx_negative}, 2'h3);
         wl(8'h04, 16'hFFFF);
         rdc(8'h04, 16'h0F3F);
         wl(8'h06, 16'hFFFF);
         rdc(8'h06, 16'h00FF);
         wl(8'h40, 16'hFFFF);
         rdc(8'h40, 16'h0000);
      end
   endtask
   task t_line;
      begin
         wl(8'h04, 16'h0000);
         chk(lv, 6'h3D);
         wl(8'h04, 16'h0010);
         chk(lv, 6'h2D);
         wl(8'h04, 16'h0012);
         chk(lv, 6'h35);
         wl(8'h04, 16'h0030);
         chk(lv, 6'h25);
         wl(8'h04, 16'h001F);
         chk(lv, 6'h12);
         wl(8'h04, 16'h003F);
         chk(lv, 6'h02);
      end
   endtask
   task t_inv;
      integer i;
      begin
         for (i = 0; i < 2; i = i + 1) begin
            m = {32{i[0]}};
            wl(8'h04, 16'h0010 | (m[15:0] & 16'h0F00));
            wl(8'h06, m[15:0] & 16'h00FF);
            chk(core_trib_tx_clock, m[30:0] ^
               {trib_tx_common_clock, drop_b_tx_clock, drop_a_tx_clock,
               trib_tx_clock});
            chk(core_trib_tx_data, m[29:0] ^
               {drop_b_tx_data, drop_a_tx_data, trib_tx_data});
            chk({trib_rx_common_clock, drop_b_rx_clock, drop_a_rx_clock,
               trib_rx_clock}, core_trib_rx_clock ^ m[30:0]);
            chk({drop_b_rx_data, drop_a_rx_data, trib_rx_data},
               core_trib_rx_data ^ m[29:0]);
            chk({framer_tx_frame_sync, framer_tx_clock, framer_tx_data,
               framer_tx_data_enable}, core_framer_tx ^ m[3:0]);
            chk(core_framer_rx, m[3:0] ^ {framer_rx_frame_sync,
               framer_rx_clock, framer_rx_data, framer_rx_data_enable});
         end
      end
   endtask
   task t_stat;
      begin
         wl(8'h0C, 16'h0007);
         one_second_tick_event <= 1'h1;
         @(posedge clk);
         one_second_tick_event <= 1'h0;
         repeat (3) @(posedge clk);
         chk(irq, 1'h1);
         rdc(8'h08, 16'h0001);
         rdc(8'h08, 16'h0000);
         chk(irq, 1'h0);
         frame_loss_alarm <= 1'h1;
         repeat (3) @(posedge clk);
         rdc(8'h08, 16'h0002);
         rdc(8'h08, 16'h0002);
         frame_loss_alarm <= 1'h0;
         repeat (3) @(posedge clk);
         chk(irq, 1'h1);
         rdc(8'h08, 16'h0002);
         rdc(8'h08, 16'h0000);
         tx_clock_loss <= 1'h1;
         repeat (3) @(posedge clk);
         chk(irq, 1'h1);
         rdc(8'h08, 16'h0004);
         rdc(8'h08, 16'h0004);
         wl(8'h0C, 16'h0003);
         chk(irq, 1'h0);
         tx_clock_loss <= 1'h0;
         repeat (3) @(posedge clk);
         rdc(8'h08, 16'h0000);
         rdc(8'h0C, 16'h0003);
         wl(8'h08, 16'hFFFF);
         rdc(8'h08, 16'h0000);
      end
   endtask
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'h0;
      t_regs;
      t_line;
      t_inv;
      t_stat;
      final_report;
   end
endmodule
